// ===== adc_self_calibration_handshake.sv
// calibration handshake, coefficient store and two's complement output pipeline
`timescale 1ns/1ps
module adc_self_calibration_handshake (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cal_start_pulse,
    input wire adc_cal_pkg::raw_sample_t rawSample,
    input wire logic [15:0] mismatchMeas,
    output logic calDone,
    output adc_cal_pkg::sample_t sample_out_bus,
    output logic sampleValid
);
    // rawSample is the offset-binary core code; mismatchMeas the per-stage measurement

    // offset binary to two's complement: invert the msb
    function automatic adc_cal_pkg::sample_t to_twos(input logic [15:0] ob);
        to_twos = {~ob[15], ob[14:0]};
    endfunction : to_twos

    // a sample moves on only while the converter is out of calibration
    function automatic logic keep_valid(input logic v, input logic ready);
        keep_valid = v && ready;
    endfunction : keep_valid

    // end of one measurement step, read by the sequencer and the coefficient store
    function automatic logic step_last(input logic [7:0] cnt);
        step_last = (cnt == 8'(adc_cal_pkg::CAL_STEP_CYCLES - 1));
    endfunction : step_last

    // start request: retimed, then edge detected
    logic startSync;
    logic startSeen_r;
    logic startSeen_nxt;
    logic startEdge;

    // the pin has no phase relation to clk, so only the second flop is read
    sync_two_flop startSyncer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .din(cal_start_pulse),
        .dout(startSync)
    );

    // a held pulse gives one edge, so a long pulse starts one run only
    always_comb begin
        startSeen_nxt = ce ? startSync : startSeen_r;
    end

    assign startEdge = startSync && !startSeen_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startSeen_r <= 1'b0;
        end else begin
            startSeen_r <= startSeen_nxt;
        end
    end

    // calibration sequencer: one armed cycle, then COEF_N steps of CAL_STEP_CYCLES
    // ce low freezes the count, so a run stretches but never loses a step
    adc_cal_pkg::cal_state_t state_r;
    adc_cal_pkg::cal_state_t state_nxt;
    logic calDone_r;
    logic calDone_nxt;
    logic [7:0] stepCnt_r;
    logic [7:0] stepCnt_nxt;
    logic [1:0] coefIdx_r;
    logic [1:0] coefIdx_nxt;

    always_comb begin
        state_nxt = state_r;
        calDone_nxt = calDone_r;
        stepCnt_nxt = stepCnt_r;
        coefIdx_nxt = coefIdx_r;
        if (ce) begin
            case (state_r)
                adc_cal_pkg::ST_IDLE: begin
                    // a start during a run is ignored: only the idle state looks at the edge
                    if (startEdge) begin
                        state_nxt = adc_cal_pkg::ST_ARMED;
                        calDone_nxt = 1'b0;
                    end
                end
                adc_cal_pkg::ST_ARMED: begin
                    // counters cleared here so a run never inherits a stale step or index
                    stepCnt_nxt = 8'h00;
                    coefIdx_nxt = 2'h0;
                    state_nxt = adc_cal_pkg::ST_MEASURE;
                end
                adc_cal_pkg::ST_MEASURE: begin
                    // relies on a running clock for the whole run
                    if (step_last(stepCnt_r)) begin
                        stepCnt_nxt = 8'h00;
                        if (coefIdx_r == 2'(adc_cal_pkg::COEF_N - 1)) begin
                            state_nxt = adc_cal_pkg::ST_IDLE;
                            calDone_nxt = 1'b1;
                        end else begin
                            coefIdx_nxt = coefIdx_r + 2'h1;
                        end
                    end else begin
                        stepCnt_nxt = stepCnt_r + 8'h01;
                    end
                end
                default: begin
                    // an illegal code falls back to idle and reports ready
                    state_nxt = adc_cal_pkg::ST_IDLE;
                    calDone_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= adc_cal_pkg::ST_IDLE;
            calDone_r <= adc_cal_pkg::DONE_RESET;
            stepCnt_r <= 8'h00;
            coefIdx_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            calDone_r <= calDone_nxt;
            stepCnt_r <= stepCnt_nxt;
            coefIdx_r <= coefIdx_nxt;
        end
    end

    // coefficient store: each entry written once, at the end of its own step
    // old values stay in use until the new run overwrites them entry by entry
    logic coefWrite;
    logic [15:0] coef_r [adc_cal_pkg::COEF_N];
    logic [15:0] coef_nxt [adc_cal_pkg::COEF_N];

    assign coefWrite = ce && (state_r == adc_cal_pkg::ST_MEASURE)
        && step_last(stepCnt_r);

    always_comb begin
        for (int i = 0; i < adc_cal_pkg::COEF_N; i++) begin
            coef_nxt[i] = coef_r[i];
        end
        if (coefWrite) begin
            coef_nxt[coefIdx_r] = mismatchMeas;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < adc_cal_pkg::COEF_N; i++) begin
                coef_r[i] <= 16'h0000;
            end
        end else begin
            coef_r <= coef_nxt;
        end
    end

    // three adding stages and the output register make the four-period latency;
    // coefficient 3 stays in the store, no stage applies it
    adc_cal_pkg::raw_sample_t pipe_r [adc_cal_pkg::PIPE_DEPTH-1];
    adc_cal_pkg::raw_sample_t pipe_nxt [adc_cal_pkg::PIPE_DEPTH-1];

    generate
        for (genvar k = 0; k < adc_cal_pkg::PIPE_DEPTH - 1; k++) begin : gStage
            // stage 0 reads the core, every later stage its predecessor
            adc_cal_pkg::raw_sample_t stageIn;

            if (k == 0) begin : gFirst
                assign stageIn = rawSample;
            end else begin : gNext
                assign stageIn = pipe_r[k-1];
            end

            // analog path is not sampled while calibrating; in-flight samples are dropped
            always_comb begin
                pipe_nxt[k] = pipe_r[k];
                if (ce) begin
                    pipe_nxt[k].valid = keep_valid(stageIn.valid, calDone_r);
                    pipe_nxt[k].code = 16'(stageIn.code + coef_r[k]);
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pipe_r[k] <= '0;
                end else begin
                    pipe_r[k] <= pipe_nxt[k];
                end
            end
        end
    endgenerate

    // output register: the valid drops in the very cycle done goes low, so no sample
    // launched before the start edge escapes into the calibration window
    adc_cal_pkg::raw_sample_t lastStage;
    logic [15:0] outBus_r;
    logic [15:0] outBus_nxt;
    logic outValid_r;
    logic outValid_nxt;

    assign lastStage = pipe_r[adc_cal_pkg::PIPE_DEPTH-2];

    always_comb begin
        outBus_nxt = outBus_r;
        outValid_nxt = outValid_r;
        if (ce) begin
            outBus_nxt = to_twos(lastStage.code);
            outValid_nxt = keep_valid(lastStage.valid, calDone_nxt);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outBus_r <= adc_cal_pkg::CODE_ZERO;
            outValid_r <= 1'b0;
        end else begin
            outBus_r <= outBus_nxt;
            outValid_r <= outValid_nxt;
        end
    end

    assign calDone = calDone_r;
    assign sample_out_bus = outBus_r;
    assign sampleValid = outValid_r;
endmodule : adc_self_calibration_handshake

// ===== adc_cal_pkg.sv
// constants and types for the converter calibration and output control
package adc_cal_pkg;
    localparam int SAMPLE_W = 16;
    localparam int COEF_N = 4;
    localparam int PIPE_DEPTH = 4;
    localparam int CAL_STEP_CYCLES = 64;
    localparam logic [15:0] CODE_POS_FS = 16'h7fff;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;
    localparam logic DONE_RESET = 1'b1;
    typedef logic [SAMPLE_W-1:0] sample_t;
    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] code;
    } raw_sample_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_MEASURE = 3'b100
    } cal_state_t;
endpackage : adc_cal_pkg

// ===== sync_two_flop.sv
// two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module sync_two_flop (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = ce ? din : meta_r;
        sync_nxt = ce ? meta_r : sync_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign dout = sync_r;
endmodule : sync_two_flop

// ===== adc_self_calibration_handshake_properties.sv
// assertions on the calibration handshake and sample stream
`timescale 1ns/1ps
module adc_self_calibration_handshake_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cal_start_pulse,
    input wire adc_cal_pkg::raw_sample_t rawSample,
    input wire logic [15:0] mismatchMeas,
    input wire logic calDone,
    input wire adc_cal_pkg::sample_t sample_out_bus,
    input wire logic sampleValid
);
    logic [8:0] lowCnt_r;
    logic [8:0] lowCnt_nxt;
    always_comb lowCnt_nxt = calDone ? 9'h000 : lowCnt_r + 9'h001;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lowCnt_r <= 9'h000;
        else lowCnt_r <= lowCnt_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_DONE_FALL: assert property ($rose(cal_start_pulse) && calDone |-> ##2 calDone ##1 !calDone)
        else $error("done did not drop on time");
    AST_DONE_LEN: assert property ($rose(calDone) |-> lowCnt_r == 9'h101)
        else $error("calibration length wrong");
    AST_DONE_CAUSE: assert property ($fell(calDone) |-> $past(cal_start_pulse, 2))
        else $error("done dropped without start");
    AST_HELD_ONCE: assert property ($rose(calDone) && cal_start_pulse |-> calDone[*4])
        else $error("held start restarted");
    AST_NO_SAMPLE_CAL: assert property (!calDone |-> !sampleValid)
        else $error("sample during calibration");
    AST_LATENCY: assert property (rawSample.valid && calDone ##1 calDone[*4] |-> sampleValid)
        else $error("sample missing");
    AST_NO_EXTRA: assert property (sampleValid |-> $past(rawSample.valid, 4))
        else $error("sample without input");
    AST_CODE_STEP: assert property (sampleValid && $past(sampleValid) |->
        16'(sample_out_bus - $past(sample_out_bus)) == 16'($past(rawSample.code, 4) - $past(rawSample.code, 5)))
        else $error("code step differs from input step");
endmodule : adc_self_calibration_handshake_properties
bind adc_self_calibration_handshake adc_self_calibration_handshake_properties adc_self_calibration_handshake_properties_i (
    .clk, .rst_n, .ce, .cal_start_pulse, .rawSample, .mismatchMeas, .calDone, .sample_out_bus, .sampleValid);

// ===== adc_host_model.sv
// host side: calibration requests and mismatch stimulus
`timescale 1ns/1ps
module adc_host_model (
    input wire logic clk,
    input wire logic calDone,
    output logic cal_start_pulse,
    output logic [15:0] mismatchMeas
);
    initial begin
        cal_start_pulse = 1'b0;
        mismatchMeas = 16'h0000;
    end
    task automatic calibrate(input int w, input logic [15:0] m);
        mismatchMeas = m; // static while calibrating
        @(negedge clk) #13 cal_start_pulse = 1'b1; // off the edge, unrelated phase
        repeat ((w < 4) ? 4 : ((w > 17000) ? 17000 : w)) @(negedge clk);
        cal_start_pulse = 1'b0;
        for (int i = 0; i < 400 && calDone !== 1'b1; i++) @(negedge clk);
        mismatchMeas = ~m; // no longer held, so show a changed value
    endtask : calibrate
endmodule : adc_host_model

// ===== adc_self_calibration_handshake_test.sv
// random and corner tests of calibration handshake and sample coding
`timescale 1ns/1ps
module adc_self_calibration_handshake_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic calDone;
    logic sampleValid;
    logic cal_start_pulse;
    logic [15:0] mismatchMeas;
    logic [15:0] coefSum = 16'h0000;
    logic [15:0] corner[3] = '{16'hffff, 16'h8000, 16'h0001};
    adc_cal_pkg::raw_sample_t rawSample = '0;
    adc_cal_pkg::sample_t sample_out_bus;
    adc_cal_pkg::sample_t expQ[$];
    bit push = 1'b1;
    int mismatches = 0;
    int tests_run = 0;
    always #50 clk = ~clk; // never stopped, calibration needs it
    adc_host_model adc_host_model_i (.clk(clk), .calDone(calDone), .cal_start_pulse(cal_start_pulse),
        .mismatchMeas(mismatchMeas));
    adc_self_calibration_handshake adc_self_calibration_handshake_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .cal_start_pulse(cal_start_pulse), .rawSample(rawSample), .mismatchMeas(mismatchMeas),
        .calDone(calDone), .sample_out_bus(sample_out_bus), .sampleValid(sampleValid));
    function automatic adc_cal_pkg::sample_t expCode(logic [15:0] raw);
        return (raw + coefSum) ^ 16'h8000;
    endfunction : expCode
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic feed(int n, logic [15:0] fixed, bit rnd);
        logic [15:0] c;
        logic v;
        repeat (n) begin
            c = rnd ? 16'($urandom) : fixed;
            v = rnd ? ($urandom_range(0, 3) != 0) : 1'b1;
            @(negedge clk);
            rawSample = {v, c};
            if (push && v) expQ.push_back(expCode(c));
        end
        @(negedge clk);
        rawSample.valid = 1'b0;
    endtask : feed
    task automatic results();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // the test checks every sample seen with sampleValid high
    always @(negedge clk) begin
        if (sampleValid === 1'b1) begin
            if (expQ.size() == 0) check("sampleValid", 16'h0000, 16'h0001);
            else check("sample_out_bus", expQ.pop_front(), sample_out_bus);
        end
    end
    initial begin
        #(100 * 6000);
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(78));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        check("calDone", 16'h0001, {15'h0000, calDone});
        foreach (corner[i]) feed(1, corner[i], 1'b0);
        feed(80, 16'h0000, 1'b1);
        repeat (6) @(negedge clk);
        $display("test codes done");
        push = 1'b0;
        fork
            adc_host_model_i.calibrate(4, 16'h0011);
            feed(250, 16'h0000, 1'b1);
        join
        check("calDone", 16'h0001, {15'h0000, calDone});
        coefSum = 16'h0033;
        push = 1'b1;
        feed(60, 16'h0000, 1'b1);
        repeat (6) @(negedge clk);
        $display("test short calibration done");
        adc_host_model_i.calibrate(400, 16'h0100);
        check("calDone", 16'h0001, {15'h0000, calDone});
        coefSum = 16'h0300;
        feed(60, 16'h0000, 1'b1);
        repeat (8) @(negedge clk);
        check("pending samples", 16'h0000, 16'(expQ.size()));
        $display("test held calibration done");
        results();
    end
endmodule : adc_self_calibration_handshake_test
